// ---- logic/spfs_pkg.sv ----
package spfs_pkg;
    localparam int NPIN = 5;
    localparam int P_TDI = 0;
    localparam int P_TDO = 1;
    localparam int P_TMS = 2;
    localparam int P_TCK = 3;
    localparam int P_ERA = 4;
    localparam int S_EXTERNAL_RESET_N = 5;
    localparam int S_BSCAN = 6;
    localparam int S_TEST = 7;
    localparam int S_SCLK = 8;
    localparam int NSYNC = 9;
    localparam logic [NSYNC-1:0] SYNC_RST = 9'h024;
    localparam int SEL_TDI = 4;
    localparam int SEL_TDO = 5;
    localparam int SEL_TMS = 6;
    localparam int SEL_TCK = 7;
    localparam int SEL_ERA = 12;
    localparam logic [31:0] SEL_MASK = 32'h0000_10F0;
    localparam logic [31:0] SEL_RST = 32'h0000_0000;
    localparam logic [7:0] A_SEL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_RSTC = 8'h08;
    localparam logic [7:0] A_PAD = 8'h0C;
    localparam int ST_SWD = 0;
    localparam int ST_BSCAN = 1;
    localparam int ST_FFPI = 2;
    localparam int ST_MFG = 3;
    localparam int ST_ERASED = 4;
    localparam int ST_EXTERNAL_RESET_N = 5;
    localparam int ST_RDRV = 6;
    localparam int RSTC_GO = 0;
    localparam int PAD_W = 4 * NPIN;
    localparam logic [PAD_W-1:0] PAD_RST = 20'h0_0000;
    localparam logic [15:0] SWD_SEQ = 16'hE79E;
    localparam logic [5:0] SWD_PRE_ONES = 6'h32;
    localparam logic [4:0] SWD_LAST_BIT = 5'h0F;
    localparam int SLOW_HZ = 32768;
    localparam int ERASE_IGNORE_MS = 100;
    localparam int ERASE_ACCEPT_MS = 220;
    localparam int ERASE_IGNORE_TICKS = (ERASE_IGNORE_MS * SLOW_HZ + 999) / 1000;
    localparam int ERASE_ACCEPT_TICKS = ERASE_ACCEPT_MS * SLOW_HZ / 1000 + 1;
    localparam int ERASE_CNT_W = 13;
    localparam int CLK_NS = 40;
    localparam int RST_MIN_NS = 1000;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CNT_W = 5;
    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe_n;
    } spfs_pad_drv_t;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } spfs_dbg_in_t;
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
        logic swdio;
        logic swdio_oe;
        logic trace;
        logic trace_en;
    } spfs_dbg_out_t;
endpackage

// ---- logic/spfs_top.sv ----
// Notes on behaviour
// - After reset all shared pins take their system function until software selects GPIO.
// - Select bit 12 picks erase request or GPIO line B12.
// - Select bits 7..4 pick TCK, TMS, TDO/trace, TDI or GPIO lines B7..B4.
// - Debug pins work as debug port from startup with no software setup.
// - Pad settings apply to debug pins in either mode.
// - Boundary-scan select high enters boundary-scan mode; low is normal.
// - Debug port starts as JTAG; serial-wire off until switch sequence.
// - Trace drives TDO line only while serial-wire debug is active.
// - Reset pin is bidirectional: device drives low, outside may pull low.
// - Reset pin resets core and peripherals, never the backup region.
// - Any external pulse length accepted (code drops pulses seen on fewer than two consecutive samples); own drive has a minimum length.
// - Out of reset the reset pin is an input, not driven.
// - Erase input debounced on slow clock; highs under 100 ms ignored.
// - Erase needs a high held over 220 ms.
// - Accepted erase requests flash and its nonvolatile bits set to all ones.
// - Erase pin as GPIO output driven high never erases.
// - Test pin picks boundary-scan test or fast programming; low is normal.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
module spfs_top #(
    parameter int ERASE_ACCEPT_TICKS = spfs_pkg::ERASE_ACCEPT_TICKS
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [spfs_pkg::NPIN-1:0] pin_in,
    output spfs_pkg::spfs_pad_drv_t pin_drv,
    input wire spfs_pkg::spfs_pad_drv_t gpio_drv,
    output logic [spfs_pkg::NPIN-1:0] gpio_in,
    output logic [spfs_pkg::PAD_W-1:0] pad_cfg,
    output spfs_pkg::spfs_dbg_in_t dbg_to,
    input wire spfs_pkg::spfs_dbg_out_t dbg_from,
    output logic swd_mode,
    input wire logic external_reset_n_in,
    output logic external_reset_n_out,
    output logic external_reset_n_oe_n,
    output logic core_rst_n,
    output logic periph_rst_n,
    input wire logic boundary_scan_select,
    input wire logic test_mode_pin,
    output logic bscan_mode,
    output logic mfg_test_mode,
    output logic ffpi_mode,
    input wire logic slow_clk,
    output logic flash_erase
);
    logic [spfs_pkg::NSYNC-1:0] raw, s1_r, s2_r, s3_r, flt_r;
    logic [31:0] sel_r, prdata_r;
    logic [spfs_pkg::PAD_W-1:0] pad_r;
    logic [spfs_pkg::NPIN-1:0] sys;
    logic wr, rd_setup, tck_g, tms_g, tck_prev_r, tck_rise, sclk_prev_r, sclk_rise, era_lvl;
    logic [5:0] ones_r;
    logic armed_r, swd_r;
    logic [4:0] bits_r;
    logic [15:0] sr_r, sr_nxt;
    logic [spfs_pkg::ERASE_CNT_W-1:0] er_cnt_r;
    logic erase_r, erased_r;
    logic drive_r;
    logic [spfs_pkg::RST_CNT_W-1:0] rcnt_r;
    logic core_rst_r, bscan_r, mfg_r, ffpi_r;
    spfs_pkg::spfs_pad_drv_t drv_r, drv_nxt;
    spfs_pkg::spfs_dbg_in_t dbg_r;
    logic [spfs_pkg::NPIN-1:0] gpio_in_r;
    localparam int ERASE_CNT_W = spfs_pkg::ERASE_CNT_W;
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == spfs_pkg::A_SEL) || (a == spfs_pkg::A_STAT) ||
                  (a == spfs_pkg::A_RSTC) || (a == spfs_pkg::A_PAD);
    endfunction

    // Pin order is TDI, TDO, TMS, TCK, erase; a clear select bit means system function
    function automatic logic [spfs_pkg::NPIN-1:0] sys_of(input logic [31:0] s);
        sys_of = ~{s[spfs_pkg::SEL_ERA], s[spfs_pkg::SEL_TCK], s[spfs_pkg::SEL_TMS],
                   s[spfs_pkg::SEL_TDO], s[spfs_pkg::SEL_TDI]};
    endfunction
    assign sys = sys_of(sel_r);
    assign raw = {slow_clk, test_mode_pin, boundary_scan_select, external_reset_n_in, pin_in};
    assign wr = psel && penable && pwrite && addr_ok(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    // Three-stage synchroniser; a level is taken only when stages two and three agree
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= spfs_pkg::SYNC_RST;
            s2_r <= spfs_pkg::SYNC_RST;
            s3_r <= spfs_pkg::SYNC_RST;
            flt_r <= spfs_pkg::SYNC_RST;
        end else if (ce) begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            flt_r <= (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
        end
    end

    // Register file
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_r <= spfs_pkg::SEL_RST;
            pad_r <= spfs_pkg::PAD_RST;
        end else if (ce && wr) begin
            if (paddr == spfs_pkg::A_SEL) begin
                sel_r <= pwdata & spfs_pkg::SEL_MASK;
            end
            if (paddr == spfs_pkg::A_PAD) begin
                pad_r <= pwdata[spfs_pkg::PAD_W-1:0];
            end
        end
    end

    // Read data is captured in the setup cycle so the access phase needs no wait
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (ce && rd_setup) begin
            prdata_r <= 32'h0000_0000;
            case (paddr)
                spfs_pkg::A_SEL: prdata_r <= sel_r;
                spfs_pkg::A_STAT: begin
                    prdata_r[spfs_pkg::ST_SWD] <= swd_r;
                    prdata_r[spfs_pkg::ST_BSCAN] <= bscan_r;
                    prdata_r[spfs_pkg::ST_FFPI] <= ffpi_r;
                    prdata_r[spfs_pkg::ST_MFG] <= mfg_r;
                    prdata_r[spfs_pkg::ST_ERASED] <= erased_r;
                    prdata_r[spfs_pkg::ST_EXTERNAL_RESET_N] <= flt_r[spfs_pkg::S_EXTERNAL_RESET_N];
                    prdata_r[spfs_pkg::ST_RDRV] <= drive_r;
                end
                spfs_pkg::A_RSTC: prdata_r[spfs_pkg::RSTC_GO] <= drive_r;
                spfs_pkg::A_PAD: prdata_r[spfs_pkg::PAD_W-1:0] <= pad_r;
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    // Pad settings follow the register in either pin mode
    assign pad_cfg = pad_r;
    // Pins given to GPIO look idle to the debug logic
    assign tck_g = sys[spfs_pkg::P_TCK] && flt_r[spfs_pkg::P_TCK];
    assign tms_g = !sys[spfs_pkg::P_TMS] || flt_r[spfs_pkg::P_TMS];
    assign tck_rise = tck_g && !tck_prev_r;
    assign sr_nxt = {tms_g, sr_r[15:1]};
    // Switch to serial-wire after 50 ones, then the 16-bit key, LSB first
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tck_prev_r <= 1'b0;
            ones_r <= 6'h00;
            armed_r <= 1'b0;
            bits_r <= 5'h00;
            sr_r <= 16'h0000;
            swd_r <= 1'b0;
        end else if (ce) begin
            tck_prev_r <= tck_g;
            if (tck_rise) begin
                sr_r <= sr_nxt;
                if (!tms_g) begin
                    ones_r <= 6'h00;
                end else if (ones_r != spfs_pkg::SWD_PRE_ONES) begin
                    ones_r <= ones_r + 6'h01;
                end
                if (!armed_r) begin
                    if (!tms_g && ones_r == spfs_pkg::SWD_PRE_ONES) begin
                        armed_r <= 1'b1;
                        bits_r <= 5'h01;
                    end
                end else begin
                    bits_r <= bits_r + 5'h01;
                    if (bits_r == spfs_pkg::SWD_LAST_BIT) begin
                        armed_r <= 1'b0;
                        if (sr_nxt == spfs_pkg::SWD_SEQ) begin
                            swd_r <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    assign swd_mode = swd_r;
    // Pad drive: system function or the GPIO controller, per select bit
    always_comb begin
        drv_nxt = gpio_drv;
        drv_nxt.oe_n = gpio_drv.oe_n | sys;
        if (sys[spfs_pkg::P_TMS] && swd_r && dbg_from.swdio_oe) begin
            drv_nxt.out[spfs_pkg::P_TMS] = dbg_from.swdio;
            drv_nxt.oe_n[spfs_pkg::P_TMS] = 1'b0;
        end
        if (sys[spfs_pkg::P_TDO]) begin
            if (swd_r) begin
                drv_nxt.out[spfs_pkg::P_TDO] = dbg_from.trace;
                drv_nxt.oe_n[spfs_pkg::P_TDO] = !dbg_from.trace_en;
            end else begin
                drv_nxt.out[spfs_pkg::P_TDO] = dbg_from.tdo;
                drv_nxt.oe_n[spfs_pkg::P_TDO] = !dbg_from.tdo_oe;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drv_r <= '{out: 5'h00, oe_n: 5'h1F};
            dbg_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
            gpio_in_r <= 5'h00;
        end else if (ce) begin
            drv_r <= drv_nxt;
            dbg_r.tck <= tck_g;
            dbg_r.tms <= tms_g;
            dbg_r.tdi <= !sys[spfs_pkg::P_TDI] || flt_r[spfs_pkg::P_TDI];
            gpio_in_r <= flt_r[spfs_pkg::NPIN-1:0] & ~sys;
        end
    end
    assign pin_drv = drv_r;
    assign dbg_to = dbg_r;
    assign gpio_in = gpio_in_r;
    // Erase: only the pin level in system mode counts, so a GPIO output never erases
    assign era_lvl = sys[spfs_pkg::P_ERA] && flt_r[spfs_pkg::P_ERA];
    assign sclk_rise = flt_r[spfs_pkg::S_SCLK] && !sclk_prev_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev_r <= 1'b0;
            er_cnt_r <= '0;
            erase_r <= 1'b0;
        end else if (ce) begin
            sclk_prev_r <= flt_r[spfs_pkg::S_SCLK];
            erase_r <= 1'b0;
            if (!era_lvl) begin
                er_cnt_r <= '0;
            end else if (sclk_rise && er_cnt_r != ERASE_CNT_W'(ERASE_ACCEPT_TICKS)) begin
                er_cnt_r <= er_cnt_r + 1'b1;
                if (er_cnt_r == spfs_pkg::ERASE_CNT_W'(ERASE_ACCEPT_TICKS - 1)) begin
                    erase_r <= 1'b1;
                end
            end
        end
    end

    // Sticky erase flag; a new erase in the clearing cycle wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            erased_r <= 1'b0;
        end else if (ce) begin
            if (erase_r) begin
                erased_r <= 1'b1;
            end else if (wr && paddr == spfs_pkg::A_STAT && pwdata[spfs_pkg::ST_ERASED]) begin
                erased_r <= 1'b0;
            end
        end
    end

    assign flash_erase = erase_r;
    // Own reset drive lasts at least the minimum even if software rewrites it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_r <= 1'b0;
            rcnt_r <= '0;
        end else if (ce) begin
            if (wr && paddr == spfs_pkg::A_RSTC && pwdata[spfs_pkg::RSTC_GO] && !drive_r) begin
                drive_r <= 1'b1;
                rcnt_r <= spfs_pkg::RST_CNT_W'(spfs_pkg::RST_MIN_CYC - 1);
            end else if (drive_r) begin
                if (rcnt_r == '0) begin
                    drive_r <= 1'b0;
                end else begin
                    rcnt_r <= rcnt_r - 1'b1;
                end
            end
        end
    end

    assign external_reset_n_out = 1'b0;
    assign external_reset_n_oe_n = !drive_r;
    // Mode pins; the backup region has no reset output here on purpose
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            core_rst_r <= 1'b1;
            bscan_r <= 1'b0;
            mfg_r <= 1'b0;
            ffpi_r <= 1'b0;
        end else if (ce) begin
            core_rst_r <= flt_r[spfs_pkg::S_EXTERNAL_RESET_N];
            bscan_r <= flt_r[spfs_pkg::S_BSCAN];
            mfg_r <= flt_r[spfs_pkg::S_TEST] && flt_r[spfs_pkg::S_BSCAN];
            ffpi_r <= flt_r[spfs_pkg::S_TEST] && !flt_r[spfs_pkg::S_BSCAN];
        end
    end
    assign core_rst_n = core_rst_r;
    assign periph_rst_n = core_rst_r;
    assign bscan_mode = bscan_r;
    assign mfg_test_mode = mfg_r;
    assign ffpi_mode = ffpi_r;
    // Helper: length of the current own reset drive
    logic [7:0] dlen_r;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dlen_r <= 8'h00;
        end else if (ce) begin
            dlen_r <= drive_r ? dlen_r + 8'h01 : 8'h00;
        end
    end
    a_sel_reset: assert property (@(posedge ref_clk) $rose(resetn) |-> sel_r == 32'h0 && !swd_r)
        else $error("pins not in system mode after reset");
    a_external_reset_n_input: assert property (@(posedge ref_clk) $rose(resetn) |-> external_reset_n_oe_n)
        else $error("reset pin driven out of reset");
    // The length counter already holds the full count in the cycle after the drive ends
    a_rst_min_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        ce && $fell(drive_r) |-> dlen_r >= 8'(spfs_pkg::RST_MIN_CYC))
        else $error("own reset pulse too short");
    a_trace_jtag: assert property (@(posedge ref_clk) disable iff (!resetn)
        ce && sys[spfs_pkg::P_TDO] && !swd_r && !dbg_from.tdo_oe |=> drv_r.oe_n[spfs_pkg::P_TDO])
        else $error("TDO line driven in JTAG mode without TDO enable");
    a_erase_gpio: assert property (@(posedge ref_clk) disable iff (!resetn)
        sel_r[spfs_pkg::SEL_ERA] && $past(sel_r[spfs_pkg::SEL_ERA]) |-> !erase_r)
        else $error("erase while pin in GPIO mode");
    a_erase_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        erase_r |-> er_cnt_r == ERASE_CNT_W'(ERASE_ACCEPT_TICKS)
            && er_cnt_r > ERASE_CNT_W'(spfs_pkg::ERASE_IGNORE_TICKS))
        else $error("erase without full hold time");
    a_erase_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        ce && !era_lvl |=> er_cnt_r == '0 ##1 !erase_r)
        else $error("debounce counter not cleared on low");
    a_gpio_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
        ce && sel_r[spfs_pkg::SEL_TCK] |=> !dbg_r.tck)
        else $error("debug clock active while pin is GPIO");
    a_bscan_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
        ce |=> bscan_r == $past(flt_r[spfs_pkg::S_BSCAN]))
        else $error("boundary-scan mode not following pin");
endmodule // spfs_top

// ---- dv/spfs_probe_model.sv ----
module spfs_probe_model #(
    parameter int SLOW_HALF = 3
) (
    input wire logic ref_clk,
    input wire spfs_pkg::spfs_pad_drv_t pin_drv,
    input wire logic rst_out,
    input wire logic rst_oe_n,
    output logic [spfs_pkg::NPIN-1:0] pin_in,
    output logic rst_lvl,
    output logic slow_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tck = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b1;
    logic era = 1'b0;
    logic ext_low = 1'b0;
    logic tog = 1'b0;
    logic [4:0] far;
    initial begin
        slow_clk = 1'b0;
        forever begin
            repeat (SLOW_HALF) @(posedge ref_clk);
            slow_clk <= ~slow_clk;
        end
    end
    // The probe never drives TDO; with no pull there, a toggling level keeps stale values from looking valid
    always @(posedge ref_clk) tog <= ~tog;
    // Erase switch open means the pull-down holds it low
    assign far = {era, tck, tms, tog, tdi};
    always_comb begin
        for (int i = 0; i < spfs_pkg::NPIN; i++) begin
            pin_in[i] = pin_drv.oe_n[i] ? far[i] : pin_drv.out[i];
        end
    end
    assign rst_lvl = ~(ext_low | (~rst_oe_n & ~rst_out));
    task automatic bit_out(input logic v);
        @(posedge ref_clk);
        tms <= v;
        tck <= 1'b0;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic swd_switch();
        for (int i = 0; i < 56; i++) bit_out(1'b1);
        for (int i = 0; i < 16; i++) bit_out(spfs_pkg::SWD_SEQ[i]);
        @(posedge ref_clk);
        tck <= 1'b0;
    endtask
    task automatic hold_erase(input int ticks);
        @(posedge ref_clk);
        era <= 1'b1;
        repeat (ticks * 2 * SLOW_HALF) @(posedge ref_clk);
        era <= 1'b0;
    endtask
endmodule // spfs_probe_model

// ---- dv/tb.sv ----
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ERA = 3300;
    localparam int SH = 3;
    localparam int TDO = spfs_pkg::P_TDO;
    logic ref_clk, resetn, ce, psel, penable, pwrite, pready, pslverr, swd_mode, rst_out, rst_oe_n, rst_lvl;
    logic core_rst_n, periph_rst_n, boundary_scan_select, test_mode_pin, bscan_mode, mfg_test_mode, ffpi_mode;
    logic slow_clk, flash_erase;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [4:0] pin_in, gpio_in;
    logic [19:0] pad_cfg;
    logic [32:0] expq[$];
    logic [32:0] exp_r;
    spfs_pkg::spfs_pad_drv_t pin_drv, gpio_drv;
    spfs_pkg::spfs_dbg_in_t dbg_to;
    spfs_pkg::spfs_dbg_out_t dbg_from;
    int failures = 0;
    int compares = 0;
    int erase_seen = 0;
    int cyc = 0;
    int cnt;
    spfs_top #(.ERASE_ACCEPT_TICKS(ERA)) dut (
        .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_drv(pin_drv), .gpio_drv(gpio_drv), .gpio_in(gpio_in), .pad_cfg(pad_cfg),
        .dbg_to(dbg_to), .dbg_from(dbg_from), .swd_mode(swd_mode), .external_reset_n_in(rst_lvl),
        .external_reset_n_out(rst_out), .external_reset_n_oe_n(rst_oe_n), .core_rst_n(core_rst_n),
        .periph_rst_n(periph_rst_n), .boundary_scan_select(boundary_scan_select),
        .test_mode_pin(test_mode_pin), .bscan_mode(bscan_mode), .mfg_test_mode(mfg_test_mode),
        .ffpi_mode(ffpi_mode), .slow_clk(slow_clk), .flash_erase(flash_erase)
    );
    spfs_probe_model #(.SLOW_HALF(SH)) prt (
        .ref_clk(ref_clk), .pin_drv(pin_drv), .rst_out(rst_out), .rst_oe_n(rst_oe_n),
        .pin_in(pin_in), .rst_lvl(rst_lvl), .slow_clk(slow_clk)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Outputs are looked at mid-cycle so the edge's own updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        expq.push_back({e, d});
        apb(1'b0, a, 32'h0);
    endtask
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite) begin
            exp_r = expq.pop_front();
            `CHK({pslverr, prdata}, exp_r)
        end
        if (flash_erase === 1'b1) erase_seen++;
        cyc++;
        if (cyc == 80000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        gpio_drv = {5'h00, 5'h1F};
        dbg_from = '0;
        boundary_scan_select = 1'b0;
        test_mode_pin = 1'b0;
        seed = 32'h0001_81A3;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        prt.tck <= 1'b1;
        prt.tms <= 1'b0;
        prt.tdi <= 1'b0;
        settle(8);
        `CHK(pin_drv.oe_n, 5'h1F)
        `CHK(dbg_to, 3'b100)
        `CHK(gpio_in, 5'h00)
        `CHK(swd_mode, 1'b0)
        `CHK(rst_oe_n, 1'b1)
        rd(spfs_pkg::A_SEL, 32'h0, 1'b0);
        rd(spfs_pkg::A_STAT, 32'h20, 1'b0);
        rd(8'h10, 32'h0, 1'b1);
        seed = lfsr(seed);
        apb(1'b1, spfs_pkg::A_SEL, seed);
        rd(spfs_pkg::A_SEL, seed & spfs_pkg::SEL_MASK, 1'b0);
        seed = lfsr(seed);
        apb(1'b1, spfs_pkg::A_PAD, seed);
        rd(spfs_pkg::A_PAD, {12'h000, seed[19:0]}, 1'b0);
        apb(1'b1, spfs_pkg::A_SEL, spfs_pkg::SEL_MASK);
        settle(8);
        `CHK(pad_cfg, seed[19:0])
        `CHK(dbg_to, 3'b011)
        `CHK(gpio_in[3:2], 2'b10)
        `CHK(gpio_in[0], 1'b0)
        seed = lfsr(seed);
        @(posedge ref_clk);
        gpio_drv <= {seed[4:0], 5'h00};
        settle(3);
        `CHK(pin_drv, {seed[4:0], 5'h00})
        @(posedge ref_clk);
        gpio_drv <= {5'h00, 5'h1F};
        apb(1'b1, spfs_pkg::A_SEL, 32'h0);
        dbg_from <= 6'b110001;
        settle(8);
        `CHK({pin_drv.oe_n[TDO], pin_drv.out[TDO]}, 2'b01)
        @(posedge ref_clk);
        dbg_from <= 6'b000011;
        settle(3);
        `CHK(pin_drv.oe_n[TDO], 1'b1)
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            boundary_scan_select <= k[0];
            test_mode_pin <= k[1];
            settle(8);
            `CHK({bscan_mode, mfg_test_mode, ffpi_mode}, {k[0], k[0] & k[1], k[1] & ~k[0]})
        end
        // Mode outputs must hold while the clock enable is low
        @(posedge ref_clk);
        ce <= 1'b0;
        {boundary_scan_select, test_mode_pin} <= 2'b00;
        settle(8);
        `CHK({bscan_mode, mfg_test_mode}, 2'b11)
        @(posedge ref_clk);
        ce <= 1'b1;
        settle(8);
        `CHK({bscan_mode, mfg_test_mode, ffpi_mode}, 3'b000)
        @(posedge ref_clk);
        prt.ext_low <= 1'b1;
        settle(9);
        `CHK({core_rst_n, periph_rst_n}, 2'b00)
        @(posedge ref_clk);
        prt.ext_low <= 1'b0;
        settle(9);
        `CHK({core_rst_n, periph_rst_n}, 2'b11)
        apb(1'b1, spfs_pkg::A_RSTC, 32'h1);
        cnt = 0;
        repeat (40) begin
            @(negedge ref_clk);
            if (rst_oe_n === 1'b0) cnt++;
        end
        `CHK(cnt, spfs_pkg::RST_MIN_CYC)
        `CHK(rst_out, 1'b0)
        prt.hold_erase(ERA - 20);
        settle(20);
        `CHK(erase_seen, 0)
        prt.hold_erase(ERA + 20);
        settle(4);
        `CHK(erase_seen, 1)
        rd(spfs_pkg::A_STAT, 32'h30, 1'b0);
        apb(1'b1, spfs_pkg::A_STAT, 32'h10);
        rd(spfs_pkg::A_STAT, 32'h20, 1'b0);
        apb(1'b1, spfs_pkg::A_SEL, 32'h1000);
        gpio_drv <= {5'h10, 5'h0F};
        settle((ERA + 20) * 2 * SH);
        `CHK(erase_seen, 1)
        `CHK(gpio_in[4], 1'b1)
        @(posedge ref_clk);
        gpio_drv <= {5'h00, 5'h1F};
        apb(1'b1, spfs_pkg::A_SEL, 32'h0);
        prt.swd_switch();
        settle(8);
        `CHK(swd_mode, 1'b1)
        `CHK({pin_drv.oe_n[TDO], pin_drv.out[TDO]}, 2'b01)
        @(posedge ref_clk);
        dbg_from <= 6'b001111;
        settle(3);
        `CHK({pin_drv.oe_n[spfs_pkg::P_TMS], pin_drv.out[spfs_pkg::P_TMS]}, 2'b01)
        rd(spfs_pkg::A_STAT, 32'h21, 1'b0);
        give_verdict();
    end
endmodule // tb
